// File: shared/clock_mode_pkg.sv
// Constants, register map and state type of the clock mode controller.
package clock_mode_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0] pll_control_offset = 8'h00;
  localparam logic [7:0] mode_control_offset = 8'h04;
  localparam logic [7:0] mode_status_offset = 8'h08;
  localparam logic [7:0] irq_status_offset = 8'h0c;
  localparam logic [7:0] irq_mask_offset = 8'h10;

  // Field positions of pll_control.
  localparam int lock_loss_irq_enable_bit = 7;
  localparam int pll_or_fll_select_bit = 6;
  localparam int clock_monitor_enable_bit = 5;
  localparam int vco_field_msb = 3;
  localparam logic [7:0] pll_control_write_mask = 8'hef;
  localparam logic [7:0] pll_control_reset = 8'h01;

  // Field positions of mode_control.
  localparam int clock_source_lsb = 0;
  localparam int internal_ref_bit = 2;
  localparam int reference_divider_lsb = 3;
  localparam int low_power_bit = 6;
  localparam logic [6:0] mode_control_reset = 7'h04;

  // Field positions of mode_status.
  localparam int lock_loss_flag_bit = 9;
  localparam int state_field_width = 9;

  // Interrupt status and mask layout.
  localparam int irq_width = 3;
  localparam int irq_lock_loss_bit = 0;
  localparam int irq_clock_loss_bit = 1;
  localparam int irq_mode_change_bit = 2;

  // Encodings.
  localparam logic [1:0] source_fll = 2'h0;
  localparam logic [1:0] source_internal = 2'h1;
  localparam logic [1:0] source_external = 2'h2;
  localparam logic [1:0] source_pll = 2'h3;
  localparam logic [1:0] debug_none = 2'h0;
  localparam logic [1:0] debug_from_fll = 2'h1;
  localparam logic [1:0] debug_dco_half = 2'h2;
  localparam logic [2:0] divider_none = 3'h0;
  localparam logic [3:0] vco_code_reserved = 4'h0;
  localparam logic [3:0] vco_code_max = 4'ha;
  localparam logic [5:0] pll_factor_step = 6'h04;
  localparam logic [5:0] pll_factor_max = 6'h28;
  localparam logic [10:0] fll_factor = 11'h400;

  typedef enum logic [8:0] {
    fll_engaged_int_mode = 9'h001,
    fll_engaged_ext_mode = 9'h002,
    fll_bypassed_int_mode = 9'h004,
    fll_bypassed_ext_mode = 9'h008,
    pll_engaged_ext_mode = 9'h010,
    pll_bypassed_ext_mode = 9'h020,
    low_power_int_mode = 9'h040,
    low_power_ext_mode = 9'h080,
    stop_mode = 9'h100
  } clock_mode_type;

endpackage

// File: verilog/clock_mode_control.sv
// Mode controller and PLL control register of the clock generator.
//
// Operation
// - Lock-loss interrupt request only while its enable and sticky flag are set.
// - Select bit clear keeps PLL off; set keeps FLL off.
// - Monitor enabled: external clock loss raises a reset request.
// - VCO field gives multiplier four times its code, 1 to 10.
// - Codes 11 to 15 give multiplier 40.
// - FLL engaged internal is the reset mode; entered on 00,1,0,000.
// - Every FLL mode locks the FLL to 1024 times the reference.
// - FLL engaged external entered on 00,0,0; software sets the divider.
// - FLL bypassed internal: source 01, internal, FLL, divider 000, LP 0.
// - FLL bypassed external: source 10, external, FLL, LP 0.
// - PLL engaged external entered on 00,0,1; software divides to 1-2 MHz.
// - PLL engaged external drives the output from the PLL.
// - PLL engaged: debug clock from DIGITAL_CTRL_OSCILLATOR/2 if debug on, else FLL off.
// - FLL modes take debug clock from the FLL and hold PLL off.
// - Brief FLL bypassed external use above FLL range is permitted.
// - Nine-state machine; apart from entering and leaving stop, it moves only between permitted state pairs.
// - Lock-loss flag sticky; set on loss after lock, write one clears.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/100ps

module clock_mode_control (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog and system status.
  input wire logic loop_locked,
  input wire logic ext_clock_lost,
  input wire logic background_debug_mode,
  input wire logic stop_request,
  // Clock steering.
  output logic [1:0] main_output_clock_source,
  output logic [1:0] debug_link_clock_source,
  output logic fll_enable,
  output logic pll_enable,
  output logic dco_open_loop,
  output logic [10:0] fll_multiplier,
  output logic [5:0] pll_multiplier,
  output logic [8:0] current_mode,
  // Requests.
  output logic clock_loss_reset_req,
  output logic lock_loss_irq,
  output logic irq
);

  localparam int irq_width = clock_mode_pkg::irq_width;

  logic [7:0] pll_control_reg;
  logic [6:0] mode_control_reg;
  logic lock_loss_flag_reg;
  logic lock_seen_reg;
  logic [irq_width-1:0] irq_status_reg;
  logic [irq_width-1:0] irq_mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  clock_mode_pkg::clock_mode_type state_reg;
  clock_mode_pkg::clock_mode_type state_next;
  clock_mode_pkg::clock_mode_type target;
  logic [1:0] source_next;
  logic [1:0] debug_next;
  logic fll_next;
  logic pll_next;
  logic dco_next;
  logic [5:0] pll_factor_next;
  logic [1:0] clock_source_select;
  logic internal_ref_select;
  logic [2:0] reference_divider;
  logic lp;
  logic pll_or_fll_select;
  logic [3:0] vco;
  logic access;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic lock_lost_event;
  logic [irq_width-1:0] irq_events;
  logic [31:0] read_word;

  assign clock_source_select = mode_control_reg[clock_mode_pkg::clock_source_lsb +: 2];
  assign internal_ref_select = mode_control_reg[clock_mode_pkg::internal_ref_bit];
  assign reference_divider = mode_control_reg[clock_mode_pkg::reference_divider_lsb +: 3];
  assign lp = mode_control_reg[clock_mode_pkg::low_power_bit];
  assign pll_or_fll_select = pll_control_reg[clock_mode_pkg::pll_or_fll_select_bit];
  assign vco = pll_control_reg[clock_mode_pkg::vco_field_msb:0];

  // The slave waits one access cycle so read data comes from a register.
  assign access = psel & penable & pready_reg;
  assign wr_en = access & pwrite & mapped;
  assign rd_en = access & ~pwrite & mapped;

  always_comb begin
    mapped = 1'b1;
    read_word = 32'h0;
    case (paddr)
      clock_mode_pkg::pll_control_offset: begin
        read_word[7:0] = pll_control_reg;
      end
      clock_mode_pkg::mode_control_offset: begin
        read_word[6:0] = mode_control_reg;
      end
      clock_mode_pkg::mode_status_offset: begin
        read_word[8:0] = state_reg;
        read_word[clock_mode_pkg::lock_loss_flag_bit] = lock_loss_flag_reg;
      end
      clock_mode_pkg::irq_status_offset: begin
        read_word[irq_width-1:0] = irq_status_reg;
      end
      clock_mode_pkg::irq_mask_offset: begin
        read_word[irq_width-1:0] = irq_mask_reg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg & ~pwrite) begin
        prdata_reg <= read_word;
      end
    end
  end

  // Bit 4 is never stored, so it reads back as zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_control_reg <= clock_mode_pkg::pll_control_reset;
      mode_control_reg <= clock_mode_pkg::mode_control_reset;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (paddr == clock_mode_pkg::pll_control_offset) begin
        pll_control_reg <= pwdata[7:0] & clock_mode_pkg::pll_control_write_mask;
      end
      if (paddr == clock_mode_pkg::mode_control_offset) begin
        mode_control_reg <= pwdata[6:0];
      end
      if (paddr == clock_mode_pkg::irq_mask_offset) begin
        irq_mask_reg <= pwdata[irq_width-1:0];
      end
    end
  end

  // Loss of lock only counts in the cycle after the active loop was locked.
  assign lock_lost_event = lock_seen_reg & ~loop_locked & (fll_enable | pll_enable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_seen_reg <= 1'b0;
    end else begin
      lock_seen_reg <= loop_locked & (fll_enable | pll_enable);
    end
  end

  // A loss arriving with the clearing write still sets the flag.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_loss_flag_reg <= 1'b0;
    end else if (lock_lost_event) begin
      lock_loss_flag_reg <= 1'b1;
    end else if (wr_en && paddr == clock_mode_pkg::mode_status_offset &&
                 pwdata[clock_mode_pkg::lock_loss_flag_bit]) begin
      lock_loss_flag_reg <= 1'b0;
    end
  end

  always_comb begin
    irq_events = '0;
    irq_events[clock_mode_pkg::irq_lock_loss_bit] = lock_lost_event;
    irq_events[clock_mode_pkg::irq_clock_loss_bit] = ext_clock_lost;
    irq_events[clock_mode_pkg::irq_mode_change_bit] = (state_next != state_reg);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else if (rd_en && paddr == clock_mode_pkg::irq_status_offset) begin
      irq_status_reg <= irq_events;
    end else begin
      irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      lock_loss_irq <= 1'b0;
      clock_loss_reset_req <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
      lock_loss_irq <= pll_control_reg[clock_mode_pkg::lock_loss_irq_enable_bit] &
                       lock_loss_flag_reg;
      clock_loss_reset_req <= ext_clock_lost &
        pll_control_reg[clock_mode_pkg::clock_monitor_enable_bit];
    end
  end

  // Mode the control bits ask for; an invalid mix keeps the present mode.
  always_comb begin
    target = state_reg;
    case (clock_source_select)
      2'h0: begin
        if (internal_ref_select && !pll_or_fll_select && reference_divider == clock_mode_pkg::divider_none) begin
          target = clock_mode_pkg::fll_engaged_int_mode;
        end else if (!internal_ref_select && !pll_or_fll_select) begin
          target = clock_mode_pkg::fll_engaged_ext_mode;
        end else if (!internal_ref_select && pll_or_fll_select) begin
          target = clock_mode_pkg::pll_engaged_ext_mode;
        end
      end
      2'h1: begin
        if (internal_ref_select && !pll_or_fll_select && lp && !background_debug_mode) begin
          target = clock_mode_pkg::low_power_int_mode;
        end else if (internal_ref_select && !pll_or_fll_select && reference_divider == clock_mode_pkg::divider_none) begin
          target = clock_mode_pkg::fll_bypassed_int_mode;
        end
      end
      2'h2: begin
        if (!internal_ref_select && lp && !background_debug_mode) begin
          target = clock_mode_pkg::low_power_ext_mode;
        end else if (!internal_ref_select && !pll_or_fll_select) begin
          target = clock_mode_pkg::fll_bypassed_ext_mode;
        end else if (!internal_ref_select) begin
          target = clock_mode_pkg::pll_bypassed_ext_mode;
        end
      end
      default: begin
        target = state_reg;
      end
    endcase
  end

  function automatic logic permitted(input logic [8:0] a, input logic [8:0] b);
    logic [8:0] pair;
    pair = a | b;
    case (pair)
      9'h003, 9'h005, 9'h009, 9'h006, 9'h00a, 9'h00c, 9'h044,
      9'h028, 9'h088, 9'h030, 9'h0a0: begin
        permitted = 1'b1;
      end
      default: begin
        permitted = 1'b0;
      end
    endcase
  endfunction

  // Stop is reachable from any mode and returns to the requested one.
  always_comb begin
    if (stop_request) begin
      state_next = clock_mode_pkg::stop_mode;
    end else if (state_reg == clock_mode_pkg::stop_mode) begin
      state_next = target;
    end else if (permitted(state_reg, target)) begin
      state_next = target;
    end else begin
      state_next = state_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= clock_mode_pkg::fll_engaged_int_mode;
    end else begin
      state_reg <= state_next;
    end
  end

  always_comb begin
    if (vco == clock_mode_pkg::vco_code_reserved || vco > clock_mode_pkg::vco_code_max) begin
      pll_factor_next = clock_mode_pkg::pll_factor_max;
    end else begin
      pll_factor_next = 6'(vco * clock_mode_pkg::pll_factor_step);
    end
  end

  always_comb begin
    source_next = clock_mode_pkg::source_fll;
    debug_next = clock_mode_pkg::debug_from_fll;
    fll_next = 1'b1;
    pll_next = 1'b0;
    dco_next = 1'b0;
    case (state_next)
      clock_mode_pkg::fll_engaged_int_mode, clock_mode_pkg::fll_engaged_ext_mode: begin
        source_next = clock_mode_pkg::source_fll;
      end
      clock_mode_pkg::fll_bypassed_int_mode: begin
        source_next = clock_mode_pkg::source_internal;
      end
      clock_mode_pkg::fll_bypassed_ext_mode: begin
        source_next = clock_mode_pkg::source_external;
      end
      clock_mode_pkg::pll_engaged_ext_mode, clock_mode_pkg::pll_bypassed_ext_mode: begin
        source_next = (state_next == clock_mode_pkg::pll_engaged_ext_mode) ?
                      clock_mode_pkg::source_pll : clock_mode_pkg::source_external;
        fll_next = 1'b0;
        pll_next = 1'b1;
        dco_next = background_debug_mode;
        debug_next = background_debug_mode ? clock_mode_pkg::debug_dco_half :
                     clock_mode_pkg::debug_none;
      end
      clock_mode_pkg::low_power_int_mode, clock_mode_pkg::low_power_ext_mode: begin
        source_next = (state_next == clock_mode_pkg::low_power_int_mode) ?
                      clock_mode_pkg::source_internal : clock_mode_pkg::source_external;
        fll_next = 1'b0;
        debug_next = clock_mode_pkg::debug_none;
      end
      default: begin
        source_next = main_output_clock_source;
        fll_next = 1'b0;
        debug_next = clock_mode_pkg::debug_none;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_output_clock_source <= clock_mode_pkg::source_fll;
      debug_link_clock_source <= clock_mode_pkg::debug_from_fll;
      fll_enable <= 1'b1;
      pll_enable <= 1'b0;
      dco_open_loop <= 1'b0;
      fll_multiplier <= clock_mode_pkg::fll_factor;
      pll_multiplier <= clock_mode_pkg::pll_factor_step;
    end else begin
      main_output_clock_source <= source_next;
      debug_link_clock_source <= debug_next;
      fll_enable <= fll_next & ~pll_or_fll_select;
      pll_enable <= pll_next & pll_or_fll_select;
      dco_open_loop <= dco_next;
      fll_multiplier <= fll_next ? clock_mode_pkg::fll_factor : 11'h0;
      pll_multiplier <= pll_factor_next;
    end
  end

  assign current_mode = state_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_irq_needs_both: assert property (
    lock_loss_irq == $past(
      pll_control_reg[clock_mode_pkg::lock_loss_irq_enable_bit] &
      lock_loss_flag_reg))
    else $error("lock-loss request without enable and flag");
  a_pll_fll_exclusive: assert property (!(fll_enable && pll_enable))
    else $error("FLL and PLL both enabled");
  a_monitor_reset: assert property (
    ext_clock_lost &&
    pll_control_reg[clock_mode_pkg::clock_monitor_enable_bit]
    |=> clock_loss_reset_req)
    else $error("clock loss without reset request");
  a_monitor_off: assert property (
    !pll_control_reg[clock_mode_pkg::clock_monitor_enable_bit]
    |=> !clock_loss_reset_req)
    else $error("reset request with monitor disabled");
  a_vco_scale: assert property (
    $stable(pll_control_reg) && vco == 4'h3 |=> pll_multiplier == 6'h0c)
    else $error("VCO multiplier wrong");
  a_vco_reserved: assert property (
    $stable(pll_control_reg) && vco > 4'ha |=> pll_multiplier == 6'h28)
    else $error("reserved VCO code not forty");
  a_pee_output: assert property (
    state_reg == clock_mode_pkg::pll_engaged_ext_mode && $stable(state_reg)
    |-> main_output_clock_source == clock_mode_pkg::source_pll)
    else $error("PLL engaged output not from PLL");
  a_fll_debug: assert property (
    state_reg == clock_mode_pkg::fll_bypassed_ext_mode && $stable(state_reg)
    |-> debug_link_clock_source == clock_mode_pkg::debug_from_fll && !pll_enable)
    else $error("FLL mode debug clock or PLL wrong");
  a_flag_sticks: assert property (
    lock_loss_flag_reg && !wr_en |=> lock_loss_flag_reg)
    else $error("lock-loss flag dropped without a write");
  a_bit4_zero: assert property (pll_control_reg[4] == 1'b0)
    else $error("reserved bit stored");

endmodule // clock_mode_control

// File: dv/tb.sv
// Self-checking testbench of the clock mode controller.
`timescale 1ns/100ps

module tb;
  localparam logic [7:0] pc = clock_mode_pkg::pll_control_offset;
  localparam logic [7:0] mc = clock_mode_pkg::mode_control_offset;
  localparam logic [7:0] ms = clock_mode_pkg::mode_status_offset;
  localparam logic [7:0] is = clock_mode_pkg::irq_status_offset;
  localparam logic [7:0] im = clock_mode_pkg::irq_mask_offset;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic loop_locked;
  logic ext_clock_lost;
  logic background_debug_mode;
  logic stop_request;
  logic [1:0] main_src;
  logic [1:0] debug_src;
  logic fll_enable;
  logic pll_enable;
  logic dco_open_loop;
  logic [10:0] fll_multiplier;
  logic [5:0] pll_multiplier;
  logic [8:0] current_mode;
  logic clock_loss_reset_req;
  logic lock_loss_irq;
  logic irq;
  logic [31:0] rd;
  logic err;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  clock_mode_control clock_mode_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_locked(loop_locked),
    .ext_clock_lost(ext_clock_lost),
    .background_debug_mode(background_debug_mode),
    .stop_request(stop_request), .main_output_clock_source(main_src),
    .debug_link_clock_source(debug_src), .fll_enable(fll_enable),
    .pll_enable(pll_enable), .dco_open_loop(dco_open_loop),
    .fll_multiplier(fll_multiplier), .pll_multiplier(pll_multiplier),
    .current_mode(current_mode),
    .clock_loss_reset_req(clock_loss_reset_req),
    .lock_loss_irq(lock_loss_irq), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The whole run needs a few hundred cycles; this ceiling cuts a hang.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Look between edges so the answer is seen while it stands.
    do begin
      @(negedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) error_cnt++;
    rd = prdata;
    err = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask

  task automatic test_reset;
    rdchk(pc, 32'hff, 32'h01);
    rdchk(mc, 32'h7f, 32'h04);
    rdchk(ms, 32'h1ff, 32'h001);
    chk(main_src, clock_mode_pkg::source_fll);
    chk(debug_src, clock_mode_pkg::debug_from_fll);
    chk(fll_multiplier, 32'h400);
    chk({fll_enable, pll_enable}, 32'h2);
    $display("test_reset done");
  endtask

  task automatic test_lock;
    rdchk(is, 32'h7, 32'h0);
    apb(1'b1, im, 32'h1);
    settle;
    chk(irq, 1'b0);
    loop_locked <= 1'b1;
    repeat (3) @(posedge pclk);
    loop_locked <= 1'b0;
    settle;
    chk(lock_loss_irq, 1'b0);
    chk(irq, 1'b1);
    rdchk(ms, 32'h200, 32'h200);
    apb(1'b1, ms, 32'h0);
    rdchk(ms, 32'h200, 32'h200);
    apb(1'b1, pc, 32'h81);
    settle;
    chk(lock_loss_irq, 1'b1);
    apb(1'b1, ms, 32'h200);
    settle;
    rdchk(ms, 32'h200, 32'h0);
    chk(lock_loss_irq, 1'b0);
    rdchk(is, 32'h1, 32'h1);
    settle;
    chk(irq, 1'b0);
    rdchk(is, 32'h1, 32'h0);
    apb(1'b1, pc, 32'h01);
    $display("test_lock done");
  endtask

  task automatic step(input logic [7:0] a, input logic [31:0] d,
                      input logic [8:0] m, input logic [1:0] s,
                      input logic f, input logic p);
    apb(1'b1, a, d);
    settle;
    chk(current_mode, m);
    chk(main_src, s);
    chk({fll_enable, pll_enable}, {f, p});
    chk(fll_multiplier, f ? 32'h400 : 32'h0);
    chk(debug_src, f ? 32'h1 : 32'h0);
  endtask

  task automatic test_monitor;
    ext_clock_lost <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(clock_loss_reset_req, 1'b0);
    ext_clock_lost <= 1'b0;
    step(mc, 32'h00, 9'h002, 2'h0, 1'b1, 1'b0);
    apb(1'b1, pc, 32'h21);
    ext_clock_lost <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(clock_loss_reset_req, 1'b1);
    ext_clock_lost <= 1'b0;
    apb(1'b1, pc, 32'h01);
    settle;
    chk(clock_loss_reset_req, 1'b0);
    step(mc, 32'h04, 9'h001, 2'h0, 1'b1, 1'b0);
    $display("test_monitor done");
  endtask

  task automatic test_vco;
    logic [31:0] exp;
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, pc, c);
      settle;
      exp = (c >= 1 && c <= 10) ? 4 * c : 40;
      chk(pll_multiplier, exp);
    end
    apb(1'b1, pc, 32'h1f);
    rdchk(pc, 32'hff, 32'h0f);
    apb(1'b1, pc, 32'h01);
    $display("test_vco done");
  endtask

  task automatic test_modes;
    step(mc, 32'h45, 9'h001, 2'h0, 1'b1, 1'b0);
    step(mc, 32'h05, 9'h004, 2'h1, 1'b1, 1'b0);
    step(mc, 32'h02, 9'h008, 2'h2, 1'b1, 1'b0);
    step(mc, 32'h00, 9'h002, 2'h0, 1'b1, 1'b0);
    step(mc, 32'h02, 9'h008, 2'h2, 1'b1, 1'b0);
    step(pc, 32'h45, 9'h020, 2'h2, 1'b0, 1'b1);
    step(mc, 32'h00, 9'h010, 2'h3, 1'b0, 1'b1);
    chk(pll_multiplier, 32'h14);
    stop_request <= 1'b1;
    settle;
    chk(current_mode, 9'h100);
    stop_request <= 1'b0;
    settle;
    chk(current_mode, 9'h010);
    background_debug_mode <= 1'b1;
    settle;
    chk(debug_src, clock_mode_pkg::debug_dco_half);
    chk(dco_open_loop, 1'b1);
    background_debug_mode <= 1'b0;
    settle;
    chk(dco_open_loop, 1'b0);
    $display("test_modes done");
  endtask

  task automatic test_unmapped;
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 8'h24, 32'hff);
    chk(err, 1'b1);
    rdchk(mc, 32'h7f, 32'h00);
    $display("test_unmapped done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    loop_locked = 1'b0;
    ext_clock_lost = 1'b0;
    background_debug_mode = 1'b0;
    stop_request = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_lock();
    test_monitor();
    test_vco();
    test_modes();
    test_unmapped();
    complete_run();
  end
endmodule // tb
